// File: design/rsq_reset_sequencer.sv
`timescale 1ns/100ps
module rsq_reset_sequencer #(
   parameter logic [14:0] STAB_TICKS_3 = 15'(rsq_pkg::STAB_TICKS_3)
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        rstPinIn,
   output logic             rstPinOut,
   output logic             rstPinOeN,
   input  wire logic        hasPorOption,
   input  wire logic        hasRstOutOption,
   input  wire logic [1:0]  waitSel,
   input  wire logic        subClkMode,
   input  wire logic        stopMode,
   input  wire logic        mainOscStable,
   input  wire logic        timebaseTick,
   input  wire logic        instCycleEn,
   input  wire logic        stbcWrite,
   input  wire logic        stbcRstBit,
   input  wire logic        wdtOverflow,
   input  wire logic        mode_select_pin_hi,
   input  wire logic        mode_select_pin_lo,
   output logic             romRd,
   output logic [15:0]      romAddr,
   input  wire logic [7:0]  romData,
   output logic [7:0]       modeByte,
   output logic [15:0]      resetVector,
   output logic             execStart,
   output logic             modeError,
   output logic             cpuRstN,
   output logic             forceMainClk,
   output logic             ioHiZ,
   output logic             ramWrBlock,
   output logic             stabWaitActive
);

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rstSync1_ff;
   logic rstSync2_ff;
   logic rstN;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync1_ff <= 1'b0;
         rstSync2_ff <= 1'b0;
      end else begin
         rstSync1_ff <= 1'b1;
         rstSync2_ff <= rstSync1_ff;
      end
   end

   assign rstN = rstSync2_ff;

   // ------------------------------------------------------------
   // Event decode
   // ------------------------------------------------------------
   rsq_pkg::rsq_state_type state_ff;
   rsq_pkg::rsq_state_type nxt_state;
   logic [2:0]             instCnt_ff;
   logic [2:0]             nxt_instCnt;
   logic [7:0]             modeByte_ff;
   logic [7:0]             vecHi_ff;
   logic                   loPend_ff;
   logic                   execStart_ff;
   logic                   needWait;
   logic                   swRst;
   logic                   intRst;
   logic                   extRst;
   logic                   instDone;
   logic                   stabStart;
   logic                   stabDone;
   logic                   inRun;
   logic                   inOscWait;
   logic                   inIntRst;
   logic                   inFetch;
   logic                   driveLow;

   // Main oscillator unusable in sub-clock, stop or while still settling
   assign needWait  = subClkMode || stopMode || !mainOscStable; // RQ2
   assign swRst     = stbcWrite && !stbcRstBit; // RQ20
   assign intRst    = swRst || wdtOverflow; // RQ20
   // Pin is only read as an outside reset while we are not pulling it
   assign extRst    = !rstPinIn && rstPinOeN;
   assign inRun     = state_ff == rsq_pkg::ST_RUN;
   assign inOscWait = state_ff == rsq_pkg::ST_OSCWAIT;
   assign inIntRst  = state_ff == rsq_pkg::ST_INTRST;
   assign inFetch   = (state_ff == rsq_pkg::ST_FMODE) || (state_ff == rsq_pkg::ST_FVHI) ||
                      (state_ff == rsq_pkg::ST_FVLO);
   assign instDone  = inIntRst && instCycleEn && (instCnt_ff == rsq_pkg::INST_RST_LAST); // RQ4
   assign stabStart = (nxt_state == rsq_pkg::ST_OSCWAIT) && !inOscWait;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         rsq_pkg::ST_BOOT: begin
            if (hasPorOption) begin
               nxt_state = rsq_pkg::ST_OSCWAIT; // RQ8
            end else begin
               nxt_state = rsq_pkg::ST_EXTWAIT; // RQ3
            end
         end
         rsq_pkg::ST_RUN: begin
            if (extRst && needWait) begin
               nxt_state = rsq_pkg::ST_OSCWAIT; // RQ6
            end else if (extRst) begin
               nxt_state = rsq_pkg::ST_EXTWAIT; // RQ7
            end else if (intRst && needWait) begin
               nxt_state = rsq_pkg::ST_OSCWAIT; // RQ5
            end else if (intRst) begin
               nxt_state = rsq_pkg::ST_INTRST; // RQ4
            end
         end
         rsq_pkg::ST_INTRST: begin
            if (instDone) begin
               nxt_state = rsq_pkg::ST_EXTWAIT;
            end
         end
         rsq_pkg::ST_OSCWAIT: begin
            // Outside reset still held after the wait is caught in EXTWAIT
            if (stabDone) begin
               nxt_state = rsq_pkg::ST_EXTWAIT; // RQ15
            end
         end
         rsq_pkg::ST_EXTWAIT: begin
            if (rstPinIn) begin
               nxt_state = rsq_pkg::ST_FMODE;
            end
         end
         rsq_pkg::ST_FMODE: begin
            nxt_state = extRst ? rsq_pkg::ST_EXTWAIT : rsq_pkg::ST_FVHI;
         end
         rsq_pkg::ST_FVHI: begin
            nxt_state = extRst ? rsq_pkg::ST_EXTWAIT : rsq_pkg::ST_FVLO;
         end
         rsq_pkg::ST_FVLO: begin
            nxt_state = extRst ? rsq_pkg::ST_EXTWAIT : rsq_pkg::ST_RUN;
         end
         default: begin
            nxt_state = rsq_pkg::ST_BOOT;
         end
      endcase
   end

   assign nxt_instCnt = !inIntRst ? 3'h0 : instCycleEn ? instCnt_ff + 3'h1 : instCnt_ff;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state_ff   <= rsq_pkg::ST_BOOT;
         instCnt_ff <= 3'h0;
      end else begin
         state_ff   <= nxt_state;
         instCnt_ff <= nxt_instCnt;
      end
   end

   // ------------------------------------------------------------
   // Stabilization timer
   // ------------------------------------------------------------
   rsq_stab_timer #(
      .TICKS_3 (STAB_TICKS_3)
   ) u_stab (
      .clk     (clk),
      .rstN    (rstN),
      .start   (stabStart),
      .tick    (timebaseTick),
      .waitSel (waitSel),
      .done    (stabDone)
   );

   // ------------------------------------------------------------
   // Mode fetch
   // ------------------------------------------------------------
   // ROM answers one cycle after the address, so capture lags a state
   assign romRd   = inFetch; // RQ13
   assign romAddr = (state_ff == rsq_pkg::ST_FMODE) ? rsq_pkg::MODE_ADDR :
                    (state_ff == rsq_pkg::ST_FVHI)  ? rsq_pkg::VEC_HI_ADDR :
                    (state_ff == rsq_pkg::ST_FVLO)  ? rsq_pkg::VEC_LO_ADDR : 16'h0000;

   logic capMode;
   logic capHi;
   logic capLo;

   assign capMode = (state_ff == rsq_pkg::ST_FVHI) && !extRst;
   assign capHi   = (state_ff == rsq_pkg::ST_FVLO) && !extRst;
   assign capLo   = (state_ff == rsq_pkg::ST_FVLO) && (nxt_state == rsq_pkg::ST_RUN);

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         modeByte_ff  <= rsq_pkg::MODE_SINGLE;
         vecHi_ff     <= 8'h00;
         loPend_ff    <= 1'b0;
         execStart_ff <= 1'b0;
      end else begin
         if (capMode) begin
            modeByte_ff <= romData; // RQ13
         end
         if (capHi) begin
            vecHi_ff <= romData; // RQ13
         end
         loPend_ff    <= capLo;
         execStart_ff <= loPend_ff && (nxt_state == rsq_pkg::ST_RUN);
      end
   end

   // Low byte arrives in the first RUN cycle, joined to the stored high byte
   logic [15:0] vecNow;
   assign vecNow = {vecHi_ff, romData};

   logic [15:0] vecHold_ff;
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         vecHold_ff <= rsq_pkg::VEC_RESET_VAL;
      end else if (loPend_ff) begin
         vecHold_ff <= vecNow; // RQ13
      end
   end

   assign modeByte    = modeByte_ff;
   assign resetVector = vecHold_ff;
   assign execStart   = execStart_ff;
   // Grounded mode pins and a single-chip mode byte are the only legal setup
   assign modeError   = mode_select_pin_hi || mode_select_pin_lo ||
                        (modeByte_ff != rsq_pkg::MODE_SINGLE); // RQ14

   // ------------------------------------------------------------
   // Reset pin and system outputs
   // ------------------------------------------------------------
   // Open-drain: data fixed low, enable decides whether the pin is pulled
   assign driveLow       = hasRstOutOption && (inOscWait || inIntRst); // RQ9 RQ10
   assign rstPinOut      = 1'b0;
   assign rstPinOeN      = !driveLow; // RQ21
   // Pin path bypasses every flop so reset acts with no clock edge
   assign cpuRstN        = rstPinIn && rstN && inRun; // RQ11
   assign forceMainClk   = !inRun; // RQ1
   assign ioHiZ          = !inRun; // RQ19
   // RAM writes cut during reset; content at that address is lost
   assign ramWrBlock     = !cpuRstN; // RQ18
   assign stabWaitActive = inOscWait;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_intrst_four_inst: assert property (@(posedge clk) disable iff (!rstN) // RQ4
      inIntRst && !(nxt_state == rsq_pkg::ST_INTRST) |-> instCnt_ff == 3'h3 && instCycleEn)
      else $error("Internal reset ended before four instruction cycles");

   a_nopor_skip_wait: assert property (@(posedge clk) disable iff (!rstN) // RQ3
      state_ff == rsq_pkg::ST_BOOT && !hasPorOption |=> state_ff == rsq_pkg::ST_EXTWAIT)
      else $error("Power-up without power-on reset used a wait");

   a_por_full_wait: assert property (@(posedge clk) disable iff (!rstN) // RQ8
      state_ff == rsq_pkg::ST_BOOT && hasPorOption |=> inOscWait)
      else $error("Power-on reset skipped stabilization wait");

   a_ext_main_nowait: assert property (@(posedge clk) disable iff (!rstN) // RQ7
      inRun && extRst && !needWait |=> state_ff == rsq_pkg::ST_EXTWAIT)
      else $error("Main-mode external reset used a wait");

   a_ext_stop_wait: assert property (@(posedge clk) disable iff (!rstN) // RQ6
      inRun && extRst && needWait |=> inOscWait)
      else $error("Stop or sub-clock external reset skipped wait");

   a_exec_after_fetch: assert property (@(posedge clk) disable iff (!rstN) // RQ13
      execStart_ff |-> inRun && $past(state_ff, 2) == rsq_pkg::ST_FVLO)
      else $error("Execution started without a full mode fetch");

   a_sub_soft_wait: assert property (@(posedge clk) disable iff (!rstN) // RQ5
      inRun && !extRst && intRst && needWait |=> inOscWait)
      else $error("Sub-clock internal reset skipped wait");

   a_wait_until_done: assert property (@(posedge clk) disable iff (!rstN) // RQ15
      inOscWait && !stabDone |=> inOscWait)
      else $error("Stabilization wait left early");

   a_pin_drive_wait: assert property (@(posedge clk) disable iff (!rstN) // RQ9
      hasRstOutOption && (inOscWait || inIntRst) |-> !rstPinOeN && !rstPinOut)
      else $error("Reset pin not driven low during reset");

   a_pin_drive_only: assert property (@(posedge clk) disable iff (!rstN) // RQ21
      !rstPinOeN |-> hasRstOutOption && !inRun)
      else $error("Reset pin driven outside reset");

   a_fetch_order: assert property (@(posedge clk) disable iff (!rstN) // RQ13
      state_ff == rsq_pkg::ST_FMODE && rstPinIn ##1 rstPinIn ##1 rstPinIn |->
      $past(romAddr, 2) == rsq_pkg::MODE_ADDR && $past(romAddr) == rsq_pkg::VEC_HI_ADDR &&
      romAddr == rsq_pkg::VEC_LO_ADDR)
      else $error("Mode fetch order wrong");

   a_vector_bytes: assert property (@(posedge clk) disable iff (!rstN) // RQ13
      execStart_ff |-> resetVector == {$past(romData, 2), $past(romData)})
      else $error("Reset vector bytes swapped or stale");

   a_pin_async_rst: assert property (@(posedge clk) disable iff (!rstN) // RQ11
      !rstPinIn |-> !cpuRstN && ioHiZ == !inRun)
      else $error("Low reset pin did not hold CPU in reset");

   a_main_after_rst: assert property (@(posedge clk) disable iff (!rstN) // RQ1
      !inRun |-> forceMainClk && ioHiZ)
      else $error("Clock not forced to main during reset");

   c_por_to_run: cover property (@(posedge clk) disable iff (!rstN)
      inOscWait ##[1:1000] execStart_ff);
   c_intrst_main: cover property (@(posedge clk) disable iff (!rstN)
      inRun && intRst && !needWait ##1 inIntRst);
   c_ext_in_sub: cover property (@(posedge clk) disable iff (!rstN)
      inRun && extRst && needWait ##1 inOscWait);
   c_fetch_abort: cover property (@(posedge clk) disable iff (!rstN)
      inFetch && extRst);

endmodule

// File: design/rsq_pkg.sv
// Behaviour
// [RQ1] Every reset ends in main clock mode
// [RQ2] Stopped or waiting oscillator forces stabilization wait
// [RQ3] Without power-on reset, no wait at power-up
// [RQ4] Main-mode software or watchdog reset: four cycles
// [RQ5] Sub-clock software or watchdog reset waits stabilization
// [RQ6] External reset in stop/sub: wait, then release
// [RQ7] External reset in main mode: no wait
// [RQ8] Power-on reset waits full stabilization time; code waits the waitSel-selected time, the same as other resets
// [RQ9] Reset output drives pin low during wait
// [RQ10] Reset output low four cycles in main mode
// [RQ11] Low reset pin resets asynchronously
// [RQ12] System keeps clock running during reset
// [RQ13] Fetch mode byte, vector high then low
// [RQ14] Mode pins grounded, mode byte single-chip
// [RQ15] Wait option time, then await pin release
// [RQ16] Stabilization wait timed by timebase output
// [RQ17] No power-on reset: pin held until stable
// [RQ18] RAM write during reset not preserved
// [RQ19] I/O pins high impedance through reset and fetch
// [RQ20] Control bit zero or watchdog overflow resets
// [RQ21] Reset pin open-drain low while reset active
package rsq_pkg;

   // ------------------------------------------------------------
   // Sequencer states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_BOOT,
      ST_RUN,
      ST_INTRST,
      ST_OSCWAIT,
      ST_EXTWAIT,
      ST_FMODE,
      ST_FVHI,
      ST_FVLO
   } rsq_state_type;

   // ------------------------------------------------------------
   // Mode fetch addresses and values
   // ------------------------------------------------------------
   localparam logic [15:0] MODE_ADDR      = 16'hfffd;
   localparam logic [15:0] VEC_HI_ADDR    = 16'hfffe;
   localparam logic [15:0] VEC_LO_ADDR    = 16'hffff;
   localparam logic [7:0]  MODE_SINGLE    = 8'h00;
   localparam logic [15:0] VEC_RESET_VAL  = 16'h0000;

   // ------------------------------------------------------------
   // Timing counts
   // ------------------------------------------------------------
   // Last count of the internal reset in instruction cycles (counts 0 to 3, four cycles)
   localparam logic [2:0]  INST_RST_LAST  = 3'h3;
   // Stabilization wait in timebase ticks (tick = 2^4 main clocks)
   localparam logic [14:0] STAB_TICKS_0   = 15'h0001;
   localparam logic [14:0] STAB_TICKS_1   = 15'h0400;
   localparam logic [14:0] STAB_TICKS_2   = 15'h1000;
   localparam int          STAB_TICKS_3   = 16384;
   localparam int          STAB_CNT_W     = 15;

endpackage

// File: design/rsq_stab_timer.sv
`timescale 1ns/100ps
module rsq_stab_timer #(
   parameter logic [14:0] TICKS_3 = 15'h4000
) (
   input  wire logic       clk,
   input  wire logic       rstN,
   input  wire logic       start,
   input  wire logic       tick,
   input  wire logic [1:0] waitSel,
   output logic            done
);

   // ------------------------------------------------------------
   // Target selection
   // ------------------------------------------------------------
   logic [rsq_pkg::STAB_CNT_W-1:0] cnt_ff;
   logic [rsq_pkg::STAB_CNT_W-1:0] nxt_cnt;
   logic [rsq_pkg::STAB_CNT_W-1:0] target;
   logic                           busy_ff;
   logic                           nxt_busy;
   logic                           done_ff;
   logic                           nxt_done;
   logic                           lastTick;

   assign target = (waitSel == 2'h0) ? rsq_pkg::STAB_TICKS_0 :
                   (waitSel == 2'h1) ? rsq_pkg::STAB_TICKS_1 :
                   (waitSel == 2'h2) ? rsq_pkg::STAB_TICKS_2 : TICKS_3;

   // ------------------------------------------------------------
   // Tick counter
   // ------------------------------------------------------------
   // Counts timebase output pulses only, so gear settings never shorten it
   assign lastTick = busy_ff && tick && (cnt_ff + 15'h0001 == target); // RQ16
   assign nxt_cnt  = start ? 15'h0000 : (busy_ff && tick) ? cnt_ff + 15'h0001 : cnt_ff;
   assign nxt_busy = start ? 1'b1 : lastTick ? 1'b0 : busy_ff;
   assign nxt_done = start ? 1'b0 : lastTick ? 1'b1 : done_ff;
   assign done     = done_ff;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         cnt_ff  <= 15'h0000;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         busy_ff <= nxt_busy;
         done_ff <= nxt_done;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_done_on_target: assert property (@(posedge clk) disable iff (!rstN) // RQ16
      $rose(done_ff) |-> $past(cnt_ff) + 15'h0001 == $past(target))
      else $error("Stabilization done before target count");

endmodule

// File: sim/rsq_ext_model.sv
`timescale 1ns/100ps
module rsq_ext_model #(
   parameter logic [15:0] VECTOR = 16'h5a3c
) (
   input  wire logic        clk,
   input  wire logic        extLow,
   input  wire logic        rstPinOut,
   input  wire logic        rstPinOeN,
   input  wire logic        romRd,
   input  wire logic [15:0] romAddr,
   output logic [7:0]       romData,
   output wire logic        rstPinIn
);
   // ------------------------------------------------------------
   // Reset pin with pull-up
   // ------------------------------------------------------------
   // Pin low while either side pulls it down
   assign rstPinIn = !(extLow || (!rstPinOeN && !rstPinOut));

   // ------------------------------------------------------------
   // Internal ROM, one cycle latency
   // ------------------------------------------------------------
   initial romData = 8'h00;
   // Unselected ROM toggles so stale data is never mistaken for an answer
   always @(posedge clk) begin
      if (romRd) begin
         case (romAddr)
            16'hfffd: romData <= 8'h00;
            16'hfffe: romData <= VECTOR[15:8];
            16'hffff: romData <= VECTOR[7:0];
            default:  romData <= ~romData;
         endcase
      end else begin
         romData <= ~romData;
      end
   end
endmodule

// File: sim/tb.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_errors++; \
   $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module tb;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        hasRstOutOption = 1'b1;
   logic        hasPorOption = 1'b1;
   logic        instCycleEn = 1'b1;
   logic        instHalf = 1'b0;
   logic        subClkMode = 1'b0;
   logic        stopMode = 1'b0;
   logic        mainOscStable = 1'b0;
   logic        timebaseTick = 1'b0;
   logic        stbcWrite = 1'b0;
   logic        stbcRstBit = 1'b1;
   logic        wdtOverflow = 1'b0;
   logic        extLow = 1'b0;
   logic [3:0]  tbDiv = 4'h0;
   wire logic   rstPinIn;
   logic        rstPinOut, rstPinOeN, romRd, execStart, modeError, cpuRstN;
   logic        forceMainClk, ioHiZ, ramWrBlock, stabWaitActive;
   logic [15:0] romAddr, resetVector;
   logic [7:0]  romData, modeByte;
   int          n_errors = 0;
   int          tests_run = 0;
   int          sawWait, oeLow, waitLen, hizBad;

   // ------------------------------------------------------------
   // Clock, timebase and instances
   // ------------------------------------------------------------
   // Clock runs through every reset phase
   initial forever #20 clk = ~clk;
   always @(negedge clk) begin
      tbDiv <= tbDiv + 4'h1;
      timebaseTick <= (tbDiv == 4'hf);
      instCycleEn <= instHalf ? tbDiv[0] : 1'b1;
   end

   rsq_reset_sequencer #(.STAB_TICKS_3(15'h0004)) u_rsq_reset_sequencer (
      .clk(clk), .rst_n(rst_n), .rstPinIn(rstPinIn), .rstPinOut(rstPinOut),
      .rstPinOeN(rstPinOeN), .hasPorOption(hasPorOption), .hasRstOutOption(hasRstOutOption),
      .waitSel(2'h3), .subClkMode(subClkMode), .stopMode(stopMode),
      .mainOscStable(mainOscStable), .timebaseTick(timebaseTick), .instCycleEn(instCycleEn),
      .stbcWrite(stbcWrite), .stbcRstBit(stbcRstBit), .wdtOverflow(wdtOverflow),
      .mode_select_pin_hi(1'b0), .mode_select_pin_lo(1'b0), .romRd(romRd),
      .romAddr(romAddr), .romData(romData), .modeByte(modeByte),
      .resetVector(resetVector), .execStart(execStart), .modeError(modeError),
      .cpuRstN(cpuRstN), .forceMainClk(forceMainClk), .ioHiZ(ioHiZ),
      .ramWrBlock(ramWrBlock), .stabWaitActive(stabWaitActive));

   rsq_ext_model #(.VECTOR(16'h5a3c)) u_rsq_ext_model (
      .clk(clk), .extLow(extLow), .rstPinOut(rstPinOut), .rstPinOeN(rstPinOeN),
      .romRd(romRd), .romAddr(romAddr), .romData(romData), .rstPinIn(rstPinIn));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic wait_exec(input int bound);
      sawWait = 0;
      oeLow = 0;
      hizBad = 0;
      waitLen = 0;
      while (waitLen < bound && execStart !== 1'b1) begin
         if (stabWaitActive === 1'b1) sawWait = 1;
         if (rstPinOeN === 1'b0) oeLow++;
         if (cpuRstN === 1'b0 && ioHiZ !== 1'b1) hizBad = 1;
         @(negedge clk);
         waitLen++;
      end
      if (execStart !== 1'b1) begin
         n_errors++;
         $display("BAD execStart exp 1 got 0");
         report_and_stop();
      end
      `CHK("modeByte", 8'h00, modeByte)
      `CHK("resetVector", 16'h5a3c, resetVector)
      `CHK("modeError", 1'b0, modeError)
      `CHK("cpuRstN", 1'b1, cpuRstN)
      `CHK("forceMainClk", 1'b0, forceMainClk)
      `CHK("ioHiZ", 0, hizBad)
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_por();
      wait_exec(400);
      `CHK("por wait", 1, sawWait)
      `CHK("por pin low", 1, oeLow > 0)
      mainOscStable = 1'b1;
      $display("test por done");
   endtask

   task automatic t_sw_main();
      int i;
      @(negedge clk) stbcWrite = 1'b1;
      @(negedge clk) stbcWrite = 1'b0;
      for (i = 0; i < 3; i++) begin
         @(negedge clk);
         `CHK("bit one write", 1'b1, cpuRstN)
      end
      stbcWrite = 1'b1;
      stbcRstBit = 1'b0;
      @(negedge clk) stbcWrite = 1'b0;
      stbcRstBit = 1'b1;
      wait_exec(200);
      `CHK("sw wait", 0, sawWait)
      `CHK("sw pin low", 4, oeLow)
      instHalf = 1'b1;
      @(negedge clk) wdtOverflow = 1'b1;
      @(negedge clk) wdtOverflow = 1'b0;
      wait_exec(200);
      `CHK("wdt wait", 0, sawWait)
      `CHK("wdt pin low", 1, oeLow == 7 || oeLow == 8)
      instHalf = 1'b0;
      $display("test software reset done");
   endtask

   task automatic t_wdt_sub();
      hasRstOutOption = 1'b0;
      subClkMode = 1'b1;
      mainOscStable = 1'b0;
      @(negedge clk) wdtOverflow = 1'b1;
      @(negedge clk) wdtOverflow = 1'b0;
      wait_exec(400);
      `CHK("sub wait", 1, sawWait)
      `CHK("no option pin", 0, oeLow)
      subClkMode = 1'b0;
      mainOscStable = 1'b1;
      hasRstOutOption = 1'b1;
      $display("test watchdog sub-clock done");
   endtask

   task automatic t_ext_main();
      @(negedge clk) extLow = 1'b1;
      #1;
      `CHK("async cpuRstN", 1'b0, cpuRstN)
      `CHK("ramWrBlock", 1'b1, ramWrBlock)
      repeat (10) @(negedge clk);
      extLow = 1'b0;
      wait_exec(100);
      `CHK("ext main wait", 0, sawWait)
      $display("test external main done");
   endtask

   task automatic t_ext_stop();
      int i;
      int held;
      held = 0;
      stopMode = 1'b1;
      mainOscStable = 1'b0;
      @(negedge clk) extLow = 1'b1;
      for (i = 0; i < 150; i++) begin
         @(negedge clk);
         if (stabWaitActive === 1'b1) held = 1;
      end
      `CHK("stop wait", 1, held)
      `CHK("wait over", 1'b0, stabWaitActive)
      `CHK("held reset", 1'b0, cpuRstN)
      extLow = 1'b0;
      wait_exec(100);
      `CHK("fetch after release", 1, waitLen < 8)
      stopMode = 1'b0;
      mainOscStable = 1'b1;
      $display("test external stop done");
   endtask

   task automatic t_no_por();
      int held;
      held = 0;
      @(negedge clk) extLow = 1'b1;
      rst_n = 1'b0;
      hasPorOption = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (20) begin
         @(negedge clk);
         if (stabWaitActive === 1'b1) held = 1;
      end
      `CHK("no por wait", 0, held)
      `CHK("pin holds cpu", 1'b0, cpuRstN)
      extLow = 1'b0;
      wait_exec(100);
      `CHK("no por release", 0, sawWait)
      $display("test no power-on reset done");
   endtask

   initial begin
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      t_por();
      t_sw_main();
      t_wdt_sub();
      t_ext_main();
      t_ext_stop();
      t_no_por();
      report_and_stop();
   end
endmodule
